// ---- sibr_ctrl.sv ----
// Power-down mode controller: idle, stop and back-up modes with stop-mode reset selection.
`timescale 1ns/1ps
module sibr_ctrl
  import sibr_pkg::*;
#(
  parameter int STAB_CNT = STAB_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Asynchronous pins and supply monitors
  input wire sibr_pins_s pins_in,
  // Same-clock events
  input wire logic [7:0] internal_irq_in,
  input wire logic watchdog_ovf_in,
  input wire logic abnormal_state_in,
  // Clock and reset control
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic osc_run_out,
  output logic sys_reset_out,
  output logic fetch_start_out,
  output logic [15:0] reset_vector_out,
  output logic port_dir_hold_out,
  output logic [1:0] clk_div_out,
  output logic idle_wake_out,
  output logic data_undefined_out,
  output logic [4:0] mode_out
);
  localparam logic [4:0] STAB_LAST = 5'(STAB_CNT - 1);

  logic rst_meta_reg;
  logic rst_n;
  sibr_pins_s pins_s;
  sibr_pins_s prev_reg;
  sibr_state_e state_reg;
  sibr_state_e state_next;
  logic [4:0] cnt_reg;
  logic rst_pend_reg;
  logic [5:0] src_reg;
  logic [5:0] src_next;
  logic go_reset;
  logic go_wake;
  logic sel_reg;
  logic [1:0] boot_cnt_reg;
  logic [7:0] key_reg;
  logic [1:0] div_reg;
  logic [7:0] imr_reg;
  logic [9:0] exten_reg;
  logic wr_pend_reg;
  logic [7:0] wadr_reg;
  logic [31:0] rd_mux;
  logic a_ok;
  logic ctl_clr;
  logic stop_exit;
  logic cmd_idle;
  logic cmd_stop;
  logic pin_hi;
  logic sup_ok;
  logic pin_rise;
  logic por_rise;
  logic ext_hit;
  logic wake_fall;
  logic irq_any;
  logic bkup_cond;

  // The reset pin itself is asynchronous; release is synchronised here.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  sibr_sync #(
    .WIDTH($bits(sibr_pins_s))
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .async_in(pins_in),
    .sync_out(pins_s)
  );

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= '0;
    else
      prev_reg <= pins_s;
  end

  // The boot option is a strap: taken once the synchroniser has filled.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_cnt_reg <= 2'h0;
      sel_reg <= 1'b0;
    end
    else if (boot_cnt_reg != 2'(BOOT_CAPTURE_CYCLES))
    begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      sel_reg <= pins_s.boot_sel;
    end
  end

  assign pin_hi = pins_s.reset_pin;
  assign sup_ok = pins_s.supply_ok;
  assign pin_rise = pin_hi & ~prev_reg.reset_pin;
  assign por_rise = pins_s.por_pulse & ~prev_reg.por_pulse;
  assign ext_hit = |(pins_s.ext_irq & ~prev_reg.ext_irq & exten_reg);
  assign wake_fall = |({prev_reg.wake_port_b_upper, prev_reg.wake_port_a}
                       & ~{pins_s.wake_port_b_upper, pins_s.wake_port_a});
  assign irq_any = ext_hit | (|(internal_irq_in & imr_reg));
  // With select 0 the detector sleeps in stop, so a dip there is ignored.
  assign bkup_cond = ~pin_hi | (~sup_ok & ~(state_reg == ST_STOP && !sel_reg));
  assign cmd_idle = wr_pend_reg && wadr_reg == OFF_CMD && hwdata_in[CMD_IDLE_BIT];
  assign cmd_stop = wr_pend_reg && wadr_reg == OFF_CMD && hwdata_in[CMD_STOP_BIT];

  always_comb
  begin
    state_next = state_reg;
    src_next = src_reg;
    go_reset = 1'b0;
    go_wake = 1'b0;
    case (state_reg)
      ST_RUN:
      begin
        if (bkup_cond)
          state_next = ST_BKUP;
        else if (watchdog_ovf_in)
        begin
          go_reset = 1'b1;
          src_next = SRC_WDT;
        end
        else if (!sel_reg && abnormal_state_in && wake_fall)
        begin
          go_reset = 1'b1;
          src_next = SRC_SED;
        end
        else if (cmd_stop && key_reg == STOP_KEY_VALUE && !abnormal_state_in)
          state_next = ST_STOP;
        else if (cmd_idle)
          state_next = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (bkup_cond)
          state_next = ST_BKUP;
        else if (watchdog_ovf_in)
        begin
          go_reset = 1'b1;
          src_next = SRC_WDT;
        end
        else if (irq_any)
          state_next = ST_RUN;
      end
      ST_STOP:
      begin
        // Only pin-side sources are seen; internal interrupts have no clock here.
        if (bkup_cond)
          state_next = ST_BKUP;
        else if (!sel_reg && por_rise)
        begin
          go_reset = 1'b1;
          src_next = SRC_INTERNAL_POWER_ON_RESET;
        end
        else if (ext_hit || wake_fall)
        begin
          go_reset = !sel_reg;
          go_wake = sel_reg;
          src_next = sel_reg ? src_reg : (ext_hit ? SRC_EXT : SRC_SED);
        end
      end
      ST_BKUP:
      begin
        if (pin_hi && sup_ok)
        begin
          go_reset = 1'b1;
          src_next = pin_rise ? SRC_PIN : SRC_LVD;
        end
      end
      ST_STAB:
      begin
        if (bkup_cond)
          state_next = ST_BKUP;
        else if (cnt_reg == STAB_LAST)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_RUN;
    endcase
    if (go_reset || go_wake)
      state_next = ST_STAB;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_STAB;
      rst_pend_reg <= 1'b1;
      src_reg <= SRC_PIN;
    end
    else
    begin
      state_reg <= state_next;
      rst_pend_reg <= (state_next == ST_STAB) &&
                      (go_reset || (state_reg == ST_STAB && rst_pend_reg));
      src_reg <= src_next;
    end
  end

  // Stabilisation counter restarts on every entry to the hold state.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 5'h00;
    else if (state_reg == ST_STAB && state_next == ST_STAB)
      cnt_reg <= cnt_reg + 5'h01;
    else
      cnt_reg <= 5'h00;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_start_out <= 1'b0;
      reset_vector_out <= RESET_VECTOR;
      data_undefined_out <= 1'b0;
      idle_wake_out <= 1'b0;
    end
    else
    begin
      fetch_start_out <= state_reg == ST_STAB && rst_pend_reg && state_next == ST_RUN;
      reset_vector_out <= RESET_VECTOR;
      if (go_reset)
        data_undefined_out <= src_next == SRC_INTERNAL_POWER_ON_RESET;
      idle_wake_out <= state_reg == ST_IDLE && state_next == ST_RUN;
    end
  end

  assign sys_reset_out = rst_pend_reg;
  assign cpu_clk_en_out = state_reg == ST_RUN;
  assign periph_clk_en_out = state_reg == ST_RUN || state_reg == ST_IDLE;
  assign osc_run_out = !(state_reg == ST_STOP || state_reg == ST_BKUP);
  assign port_dir_hold_out = state_reg == ST_IDLE;
  assign clk_div_out = div_reg;
  assign mode_out = state_reg;

  // Bus slave: zero wait states, reads registered in the address phase.
  assign a_ok = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign ctl_clr = state_reg == ST_STAB && rst_pend_reg;
  assign stop_exit = state_reg == ST_STOP && state_next != ST_STOP;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr_in[7:0])
      OFF_KEY: rd_mux = {24'h0, key_reg};
      OFF_DIV: rd_mux = {30'h0, div_reg};
      OFF_IMR: rd_mux = {24'h0, imr_reg};
      OFF_EXTEN: rd_mux = {22'h0, exten_reg};
      OFF_STATUS: rd_mux = {19'h0, data_undefined_out, src_reg, sel_reg, state_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wadr_reg <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= a_ok && hwrite_in && hsize_in == 3'h2;
      if (a_ok)
        wadr_reg <= haddr_in[7:0];
      if (a_ok && !hwrite_in)
        hrdata_out <= rd_mux;
    end
  end

  // Control registers fall back to defaults on every system reset.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_reg <= KEY_RESET;
      div_reg <= DIV_RESET;
      exten_reg <= EXTEN_RESET;
    end
    else if (ctl_clr)
    begin
      key_reg <= KEY_RESET;
      div_reg <= DIV_RESET;
      exten_reg <= EXTEN_RESET;
    end
    else
    begin
      if (stop_exit)
        key_reg <= KEY_RESET;
      else if (wr_pend_reg && wadr_reg == OFF_KEY)
        key_reg <= hwdata_in[7:0];
      if (wr_pend_reg && wadr_reg == OFF_DIV)
        div_reg <= hwdata_in[1:0];
      if (wr_pend_reg && wadr_reg == OFF_EXTEN)
        exten_reg <= hwdata_in[9:0];
    end
  end

  // The mask register has no hardware default beyond power-up.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      imr_reg <= IMR_RESET;
    else if (wr_pend_reg && wadr_reg == OFF_IMR)
      imr_reg <= hwdata_in[7:0];
  end

  a_stop_key_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_RUN && cmd_stop && key_reg != STOP_KEY_VALUE |=> state_reg != ST_STOP)
    else $error("stop entered without key");

  a_key_cleared: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_STOP ##1 state_reg != ST_STOP |-> key_reg == KEY_RESET)
    else $error("stop key not cleared on release");

  a_backup_entry: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_reg == ST_RUN || state_reg == ST_IDLE) && !pin_hi |=> state_reg == ST_BKUP && !osc_run_out)
    else $error("back-up not entered on pin low");

  a_backup_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_BKUP && !sup_ok |=> state_reg == ST_BKUP)
    else $error("back-up left without supply");

  a_reset_width: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(sys_reset_out) && !bkup_cond |-> sys_reset_out[*8] ##1 sys_reset_out[*8])
    else $error("system reset shorter than sixteen clocks");

  a_idle_clocks: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_IDLE |-> !cpu_clk_en_out && periph_clk_en_out && port_dir_hold_out)
    else $error("idle clock gating wrong");

  a_idle_wake: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_IDLE && irq_any && !bkup_cond && !watchdog_ovf_in
    |=> state_reg == ST_RUN && idle_wake_out && div_reg == $past(div_reg))
    else $error("idle not released by interrupt");

  a_stop_ext_rst: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_STOP && !sel_reg && ext_hit && !bkup_cond && !por_rise
    |=> sys_reset_out ##16 fetch_start_out)
    else $error("external interrupt in stop did not reset");

  a_stop_wake_only: assert property (@(posedge clk_in) disable iff (!rst_n)
    state_reg == ST_STOP && sel_reg && (ext_hit || wake_fall) && !bkup_cond
    |=> state_reg == ST_STAB && !sys_reset_out)
    else $error("select 1 release produced a reset");

  a_fetch_vector: assert property (@(posedge clk_in) disable iff (!rst_n)
    fetch_start_out |-> $past(sys_reset_out) && reset_vector_out == 16'h0100 && cpu_clk_en_out)
    else $error("fetch without reset vector");

endmodule

// ---- sibr_pkg.sv ----
// Shared constants, states and pin bundle for the stop, idle and back-up controller.
package sibr_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFF_KEY = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_IMR = 8'h08;
  localparam logic [7:0] OFF_EXTEN = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Field positions and reset values.
  localparam int CMD_IDLE_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam logic [7:0] STOP_KEY_VALUE = 8'hA5;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam logic [9:0] EXTEN_RESET = 10'h000;
  localparam logic [15:0] RESET_VECTOR = 16'h0100;

  // Oscillation stabilisation hold and boot strap capture, in oscillator clocks.
  localparam int STAB_CYCLES = 16;
  localparam int BOOT_CAPTURE_CYCLES = 3;

  // Reset source flags, one-hot.
  localparam logic [5:0] SRC_PIN = 6'h01;
  localparam logic [5:0] SRC_LVD = 6'h02;
  localparam logic [5:0] SRC_INTERNAL_POWER_ON_RESET = 6'h04;
  localparam logic [5:0] SRC_EXT = 6'h08;
  localparam logic [5:0] SRC_SED = 6'h10;
  localparam logic [5:0] SRC_WDT = 6'h20;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_IDLE = 5'h02,
    ST_STOP = 5'h04,
    ST_BKUP = 5'h08,
    ST_STAB = 5'h10
  } sibr_state_e;

  // Asynchronous pin-side inputs, all synchronised before use.
  typedef struct packed {
    logic boot_sel;
    logic por_pulse;
    logic supply_ok;
    logic reset_pin;
    logic [3:0] wake_port_b_upper;
    logic [7:0] wake_port_a;
    logic [9:0] ext_irq;
  } sibr_pins_s;

endpackage

// ---- sibr_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module sibr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ---- sibr_far_side.sv ----
// Far-side model: reset pin, wake pins, external interrupts and supply monitors.
`timescale 1ns/1ps
module sibr_far_side
  import sibr_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Pin levels seen by the controller
  output sibr_pins_s pins_out
);
  initial
  begin
    pins_out = {1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'hFF, 10'h000};
  end
  task automatic strap(input logic v);
    pins_out.boot_sel <= v;
  endtask
  task automatic rst_pin(input logic v);
    pins_out.reset_pin <= v;
  endtask
  // Events last four cycles so the two-flop synchroniser cannot miss them.
  task automatic irq(input int i);
    pins_out.ext_irq[i] <= 1'b1;
    repeat (4) @(posedge clk_in);
    pins_out.ext_irq[i] <= 1'b0;
  endtask
  // Wake pins have pull-ups, so a released pin returns high.
  // Indices 0 to 7 pick port A, 8 to 11 the upper half of port B.
  task automatic wake(input int i);
    if (i < 8)
      pins_out.wake_port_a[i] <= 1'b0;
    else
      pins_out.wake_port_b_upper[i - 8] <= 1'b0;
    repeat (4) @(posedge clk_in);
    pins_out.wake_port_a <= 8'hFF;
    pins_out.wake_port_b_upper <= 4'hF;
  endtask
  // The power-on pulse comes only after a full collapse; a dip gives none.
  task automatic supply(input logic full);
    pins_out.supply_ok <= 1'b0;
    repeat (4) @(posedge clk_in);
    pins_out.por_pulse <= full;
    pins_out.supply_ok <= 1'b1;
    repeat (4) @(posedge clk_in);
    pins_out.por_pulse <= 1'b0;
  endtask
endmodule

// ---- stop_idle_backup_reset_control_tb.sv ----
// Self-checking bench for the stop, idle and back-up controller.
`timescale 1ns/1ps
module stop_idle_backup_reset_control_tb;
  import sibr_pkg::*;
  localparam int STAB = STAB_CYCLES;
  logic clk_in;
  logic arst_n_in;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rq;
  logic hready;
  logic hresp;
  logic cpu_en;
  logic per_en;
  logic osc;
  logic sysr;
  logic fetch;
  logic dir_hold;
  logic iwake;
  logic undef;
  logic abn;
  logic wdt;
  logic [2:0] seen;
  logic [1:0] div;
  logic [4:0] mode;
  logic [7:0] int_irq;
  logic [15:0] vec;
  logic [15:0] lfsr;
  sibr_pins_s pins;
  int error_cnt;
  int checked;
  int cyc;
  logic [7:0] offs [4] = '{OFF_KEY, OFF_DIV, OFF_IMR, OFF_EXTEN};
  logic [31:0] rsts [4] = '{{24'h0, KEY_RESET}, {30'h0, DIV_RESET}, {24'h0, IMR_RESET},
    {22'h0, EXTEN_RESET}};
  logic [31:0] masks [4] = '{32'hFF, 32'h3, 32'hFF, 32'h3FF};

  sibr_far_side u_far (.clk_in(clk_in), .pins_out(pins));
  sibr_ctrl #(.STAB_CNT(STAB)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .pins_in(pins), .internal_irq_in(int_irq),
    .watchdog_ovf_in(wdt), .abnormal_state_in(abn), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .osc_run_out(osc), .sys_reset_out(sysr),
    .fetch_start_out(fetch), .reset_vector_out(vec), .port_dir_hold_out(dir_hold),
    .clk_div_out(div), .idle_wake_out(iwake), .data_undefined_out(undef), .mode_out(mode));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Pulses are caught mid-cycle so the clearing edge never races them.
  always @(negedge clk_in)
    seen <= seen | {iwake === 1'b1, fetch === 1'b1, sysr === 1'b1};

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [5:0] exp_src(input int k);
    return k == 0 ? SRC_EXT : k == 1 ? SRC_SED : k == 2 ? SRC_INTERNAL_POWER_ON_RESET : SRC_LVD;
  endfunction

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do
      @(posedge clk_in);
    while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge clk_in);
    while (hready !== 1'b1);
    rq = hrdata;
  endtask

  task automatic wait_mode(input logic [4:0] m);
    for (int n = 0; n < 200 && mode !== m; n++)
      @(posedge clk_in);
    chk_val("mode", {27'h0, m}, {27'h0, mode});
  endtask

  task automatic stop_rel(input int k, input int i);
    int n;
    logic r;
    r = !pins.boot_sel || k == 3;
    bus(1'b1, OFF_EXTEN, 32'h3FF);
    bus(1'b1, OFF_KEY, {24'h0, STOP_KEY_VALUE});
    bus(1'b1, OFF_CMD, 32'h2);
    wait_mode(ST_STOP);
    chk_bit("osc run", 1'b0, osc);
    chk_bit("cpu clock", 1'b0, cpu_en);
    if (k == 0 && !pins.boot_sel)
    begin
      int_irq <= 8'hFF;
      wdt <= 1'b1;
      u_far.supply(1'b0);
      chk_val("mode", {27'h0, ST_STOP}, {27'h0, mode});
      int_irq <= 8'h00;
      wdt <= 1'b0;
    end
    seen <= 3'h0;
    fork
      case (k)
        0: u_far.irq(i);
        1: u_far.wake(i + 2);
        default: u_far.supply(k == 2);
      endcase
    join_none
    for (n = 0; n < 60 && mode !== ST_STAB; n++)
      @(posedge clk_in);
    for (n = 0; n < 60 && mode === ST_STAB; n++)
      @(posedge clk_in);
    chk_val("hold length", STAB, n);
    wait_mode(ST_RUN);
    chk_bit("sys reset", r, seen[0]);
    chk_bit("fetch", r, seen[1]);
    chk_bit("undefined", k == 2, undef);
    bus(1'b0, OFF_KEY, 32'h0);
    chk_val("key", {24'h0, KEY_RESET}, rq);
    bus(1'b0, OFF_STATUS, 32'h0);
    if (r)
      chk_val("source", {26'h0, exp_src(k)}, {26'h0, rq[11:6]});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    arst_n_in = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    int_irq = 8'h00;
    wdt = 1'b0;
    abn = 1'b0;
    seen = 3'h0;
    lfsr = 16'h001A;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    wait_mode(ST_RUN);
    chk_val("vector", {16'h0, RESET_VECTOR}, {16'h0, vec});
    for (int j = 0; j < 4; j++)
    begin
      bus(1'b0, offs[j], 32'h0);
      chk_val("reset value", rsts[j], rq);
      lfsr = lfsr_next(lfsr);
      bus(1'b1, offs[j], {lfsr, lfsr});
      bus(1'b0, offs[j], 32'h0);
      chk_val("readback", {lfsr, lfsr} & masks[j], rq);
    end
    bus(1'b1, 8'h40, 32'hFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk_val("unmapped", 32'h0, rq);
    chk_bit("hresp", 1'b0, hresp);
    bus(1'b1, OFF_DIV, 32'h3);
    bus(1'b1, OFF_IMR, 32'h0);
    bus(1'b1, OFF_CMD, 32'h1);
    wait_mode(ST_IDLE);
    chk_bit("cpu clock", 1'b0, cpu_en);
    chk_bit("periph clock", 1'b1, per_en);
    chk_bit("dir hold", 1'b1, dir_hold);
    int_irq <= 8'h01;
    repeat (10) @(posedge clk_in);
    chk_val("mode", {27'h0, ST_IDLE}, {27'h0, mode});
    seen <= 3'h0;
    bus(1'b1, OFF_IMR, 32'h1);
    wait_mode(ST_RUN);
    int_irq <= 8'h00;
    chk_bit("idle wake", 1'b1, seen[2]);
    chk_val("divider", 32'h3, {30'h0, div});
    bus(1'b1, OFF_CMD, 32'h1);
    wait_mode(ST_IDLE);
    u_far.rst_pin(1'b0);
    wait_mode(ST_BKUP);
    chk_bit("osc run", 1'b0, osc);
    wdt <= 1'b1;
    int_irq <= 8'hFF;
    repeat (10) @(posedge clk_in);
    chk_val("mode", {27'h0, ST_BKUP}, {27'h0, mode});
    wdt <= 1'b0;
    int_irq <= 8'h00;
    u_far.rst_pin(1'b1);
    wait_mode(ST_RUN);
    bus(1'b0, OFF_DIV, 32'h0);
    chk_val("divider", {30'h0, DIV_RESET}, rq);
    for (int j = 0; j < 2; j++)
    begin
      abn <= (j == 0);
      bus(1'b1, OFF_KEY, j ? 32'h5A : 32'hA5);
      bus(1'b1, OFF_CMD, 32'h2);
      repeat (4) @(posedge clk_in);
      chk_val("refused stop", {27'h0, ST_RUN}, {27'h0, mode});
    end
    // A wake edge while running in the abnormal state resets through recovery.
    abn <= 1'b1;
    u_far.wake(11);
    wait_mode(ST_STAB);
    abn <= 1'b0;
    wait_mode(ST_RUN);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk_val("source", {26'h0, SRC_SED}, {26'h0, rq[11:6]});
    wdt <= 1'b1;
    @(posedge clk_in);
    wdt <= 1'b0;
    wait_mode(ST_STAB);
    wait_mode(ST_RUN);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk_val("source", {26'h0, SRC_WDT}, {26'h0, rq[11:6]});
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      stop_rel(k, int'(lfsr % 16'h000A));
    end
    arst_n_in <= 1'b0;
    u_far.strap(1'b1);
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    wait_mode(ST_RUN);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk_bit("select", 1'b1, rq[5]);
    stop_rel(0, 9);
    stop_rel(3, 0);
    tally_and_finish;
  end
endmodule
